// [shared/modem_pkg.sv]
// shared constants, register map and types of the fsk modem supervisory block
package modem_pkg;

	// ****************************************************************
	// clock and timing figures
	// ****************************************************************
	localparam int CLK_HZ         = 100_000_000;
	localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int US_IN_MS       = 1000;
	localparam int T_BRK_HOLD_MS  = 34;
	localparam int T_BRK_SEND_MS  = 233;
	localparam int T_RX_BRK_MS    = 150;
	localparam int T_BRK_REL_US   = 20;
	localparam int T_DTR_MS       = 34;
	localparam int T_DISC_MS      = 3000;
	localparam int T_RING_MS      = 51;
	localparam int RING_CYCLES    = 20;
	localparam int T_RING_GAP_MS  = 100;
	localparam int T_HOOK_MS      = 17000;
	localparam int T_LVL_PULSE_US = 20;
	localparam int T_LVL_GAP_MS   = 32;
	localparam int T_SPACE_LO_US  = 429;
	localparam int T_SPACE_HI_US  = 235;
	localparam int F_ORIG_MARK    = 1270;
	localparam int F_ORIG_SPACE   = 1070;
	localparam int F_ANS_MARK     = 2225;
	localparam int F_ANS_SPACE    = 2025;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_LOSS      = 8'h04;
	localparam logic [7:0] ADDR_STATUS    = 8'h08;
	localparam int         CTRL_RING_LVL  = 0;
	localparam int         STAT_CALL_LSB  = 0;
	localparam int         STAT_ORIG      = 2;
	localparam int         STAT_CTS_N     = 3;
	localparam int         STAT_RX_BRK    = 4;
	localparam int         STAT_OFFHOOK   = 5;
	localparam int         STAT_CARRIER   = 6;
	localparam int         STAT_LOST      = 7;
	localparam int         STAT_CLAMP     = 8;
	localparam int         STAT_TX_BIT    = 9;
	localparam logic [2:0] HSIZE_WORD     = 3'h2;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		CALL_IDLE   = 2'h0,
		CALL_WAIT   = 2'h1,
		CALL_ONLINE = 2'h3,
		CALL_DISC   = 2'h2
	} call_t;

	typedef struct packed {
		logic tx_data;
		logic brk_n;
		logic clr_n;
		logic loop_n;
		logic fast;
		logic disc_en;
		logic long_n;
		logic short_n;
		logic hook_n;
		logic ring_n;
		logic dtr_n;
		logic lvl_n;
		logic rx_tone;
	} pins_t;

	localparam pins_t PINS_IDLE = 13'h1E7E;

	typedef struct packed {
		pins_t       s1;
		pins_t       s2;
		pins_t       s3;
		pins_t       pin;
		pins_t       pin_q;
		call_t       call;
		logic        orig;
		logic [15:0] us_div;
		logic [15:0] ms_div;
		logic [15:0] brk_hi;
		logic [15:0] brk_low;
		logic [15:0] brk_send;
		logic [15:0] rx_half;
		logic [15:0] rx_sp_ms;
		logic [15:0] rel_us;
		logic [15:0] dtr_hi;
		logic [15:0] disc_ms;
		logic [15:0] hook_ms;
		logic [15:0] ring_cnt;
		logic [15:0] ring_low;
		logic [15:0] ring_gap;
		logic [15:0] lvl_low;
		logic [15:0] lvl_gap;
		logic [15:0] loss_ms;
		logic [15:0] loss_limit;
		logic        brk_armed;
		logic        rx_space;
		logic        clamp;
		logic        disc_space;
		logic        carrier_ok;
		logic        ctrl_level;
		logic        wr_pend;
		logic        tx_bit;
		logic [7:0]  wr_addr;
		logic [31:0] hrdata;
		logic [31:0] phase;
		logic [31:0] inc;
		logic        hreadyout;
		logic        hresp;
		logic        rx_out;
		logic        rx_brk;
		logic        cts_n;
		logic        mode_out;
		logic        offhook;
	} state_t;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		return (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction

	function automatic logic [31:0] tone_inc(input int hz);
		logic [63:0] t;
		t = (64'(hz) << 32) / 64'(CLK_HZ);
		return t[31:0];
	endfunction

	function automatic logic [31:0] tone_sel(input logic orig, input logic mark);
		if (orig)
			return mark ? tone_inc(F_ORIG_MARK) : tone_inc(F_ORIG_SPACE);
		return mark ? tone_inc(F_ANS_MARK) : tone_inc(F_ANS_SPACE);
	endfunction

endpackage

// [logic/fsk_modem_supervisory_control.sv]
// supervisory, timing and tone logic of the fsk modem with an ahb-lite register slave
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

module fsk_modem_supervisory_control
	import modem_pkg::*;
#(
	parameter int CYC_PER_US      = CLK_MHZ,
	parameter int US_PER_MS       = US_IN_MS,
	parameter int HOOK_TIMEOUT_MS = T_HOOK_MS,
	parameter int LOSS_MS         = 500,
	parameter int LONG_SPACE_MS   = 1500,
	parameter int SHORT_SPACE_MS  = 300
)
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        tx_serial_in,
	input  wire logic        tx_break_req_n,
	input  wire logic        break_clear_n,
	input  wire logic        loopback_test_n,
	input  wire logic        fast_test_en,
	input  wire logic        space_disc_en,
	input  wire logic        long_space_hangup_n,
	input  wire logic        short_space_hangup_n,
	input  wire logic        hook_switch_n,
	input  wire logic        ring_ind_n,
	input  wire logic        term_ready_n,
	input  wire logic        carrier_level_ok_n,
	input  wire logic        rx_tone_in,
	output logic             rx_serial_out,
	output logic             rx_break_flag,
	output logic             clear_to_send_n,
	output logic             originate_mode,
	output logic             tone_freq_out,
	output logic             tx_tone_out,
	output logic             offhook_drive
);

	// ****************************************************************
	// state and reset value
	// ****************************************************************
	function automatic state_t reset_value();
		state_t r;
		r            = '0;
		r.s1         = PINS_IDLE;
		r.s2         = PINS_IDLE;
		r.s3         = PINS_IDLE;
		r.pin        = PINS_IDLE;
		r.pin_q      = PINS_IDLE;
		r.call       = CALL_IDLE;
		r.loss_limit = 16'(LOSS_MS);
		r.tx_bit     = 1'b1;
		r.inc        = tone_sel(1'b0, 1'b1);
		r.hreadyout  = 1'b1;
		r.rx_out     = 1'b1;
		r.rx_brk     = 1'b1;
		r.cts_n      = 1'b1;
		return r;
	endfunction

	localparam state_t      RESET_STATE = reset_value();
	localparam logic [15:0] US_LAST     = 16'(CYC_PER_US - 1);
	localparam logic [15:0] MS_LAST     = 16'(US_PER_MS - 1);

	state_t      cur;
	state_t      next_cur;
	pins_t       pins_now;
	logic        us_tick;
	logic        ms_tick;
	logic        band_hi;
	logic [15:0] rx_thresh;
	logic        rx_edge;
	logic        space_now;
	logic        clamp_set;
	logic        clamp_release;
	logic        lost;
	logic        ring_ok;
	logic        dtr_drop;
	logic        brk_fall;
	logic        disc_rise;
	logic        mode_calc;
	logic        accept;
	logic [31:0] status_word;

	assign pins_now = '{tx_serial_in, tx_break_req_n, break_clear_n, loopback_test_n, fast_test_en,
		space_disc_en, long_space_hangup_n, short_space_hangup_n, hook_switch_n, ring_ind_n,
		term_ready_n, carrier_level_ok_n, rx_tone_in};

	always_comb
	begin
		next_cur      = cur;
		// ****************************************************************
		// pin synchronisers: a change counts once stages two and three agree
		// ****************************************************************
		next_cur.s1    = pins_now;
		next_cur.s2    = cur.s1;
		next_cur.s3    = cur.s2;
		next_cur.pin   = pins_t'((cur.s2 & cur.s3) | (cur.pin & (cur.s2 | cur.s3)));
		next_cur.pin_q = cur.pin;

		// ****************************************************************
		// reference ticks
		// ****************************************************************
		us_tick = (cur.us_div == US_LAST);
		next_cur.us_div = us_tick ? 16'h0000 : cur.us_div + 16'h0001;
		if (us_tick)
			next_cur.ms_div = (cur.ms_div == MS_LAST) ? 16'h0000 : cur.ms_div + 16'h0001;
		// fast test turns every microsecond into a timer millisecond
		ms_tick = cur.pin.fast ? us_tick : (us_tick && cur.ms_div == MS_LAST);

		// ****************************************************************
		// level detect supervision
		// ****************************************************************
		if (!cur.pin.lvl_n)
			next_cur.lvl_low = us_tick ? sat_inc(cur.lvl_low) : cur.lvl_low;
		else
			next_cur.lvl_low = 16'h0000;
		if (cur.lvl_low >= 16'(T_LVL_PULSE_US))
		begin
			// a fresh pulse wins over a gap expiring in the same cycle
			next_cur.carrier_ok = 1'b1;
			next_cur.lvl_gap    = 16'h0000;
		end
		else
		begin
			if (ms_tick)
				next_cur.lvl_gap = sat_inc(cur.lvl_gap);
			if (cur.lvl_gap >= 16'(T_LVL_GAP_MS))
				next_cur.carrier_ok = 1'b0;
		end
		if (cur.carrier_ok)
			next_cur.loss_ms = 16'h0000;
		else if (ms_tick)
			next_cur.loss_ms = sat_inc(cur.loss_ms);
		lost = !cur.carrier_ok && (cur.loss_ms >= cur.loss_limit);

		// ****************************************************************
		// receive demodulator: half-cycle length decides mark or space
		// ****************************************************************
		mode_calc = cur.orig ^ !cur.pin.loop_n;
		band_hi   = mode_calc;
		rx_thresh = band_hi ? 16'(T_SPACE_HI_US) : 16'(T_SPACE_LO_US);
		rx_edge   = (cur.pin.rx_tone != cur.pin_q.rx_tone);
		if (rx_edge)
		begin
			space_now        = (cur.rx_half >= rx_thresh);
			next_cur.rx_half = 16'h0000;
		end
		else
		begin
			space_now        = (cur.rx_half >= rx_thresh) || cur.rx_space;
			next_cur.rx_half = us_tick ? sat_inc(cur.rx_half) : cur.rx_half;
		end
		next_cur.rx_space = space_now;
		// data is held at mark while the carrier is judged absent
		next_cur.rx_out   = next_cur.carrier_ok ? !space_now : 1'b1;

		if (space_now && cur.carrier_ok)
			next_cur.rx_sp_ms = ms_tick ? sat_inc(cur.rx_sp_ms) : cur.rx_sp_ms;
		else
			next_cur.rx_sp_ms = 16'h0000;
		clamp_set = (next_cur.rx_sp_ms >= 16'(T_RX_BRK_MS)) && (cur.rx_sp_ms < 16'(T_RX_BRK_MS));
		if (!cur.pin.clr_n && cur.clamp)
			next_cur.rel_us = us_tick ? sat_inc(cur.rel_us) : cur.rel_us;
		else
			next_cur.rel_us = 16'h0000;
		clamp_release = (cur.rel_us >= 16'(T_BRK_REL_US));
		next_cur.clamp = clamp_set || (cur.clamp && !clamp_release);

		// ****************************************************************
		// transmit break
		// ****************************************************************
		brk_fall = !cur.pin.brk_n && cur.pin_q.brk_n;
		if (cur.pin.brk_n)
		begin
			next_cur.brk_hi    = ms_tick ? sat_inc(cur.brk_hi) : cur.brk_hi;
			next_cur.brk_low   = 16'h0000;
			next_cur.brk_armed = 1'b0;
		end
		else
		begin
			next_cur.brk_hi = 16'h0000;
			if (brk_fall)
				next_cur.brk_armed = (cur.brk_hi >= 16'(T_BRK_HOLD_MS)) && (cur.call == CALL_ONLINE);
			if (cur.brk_armed && ms_tick)
				next_cur.brk_low = sat_inc(cur.brk_low);
		end
		if (cur.brk_armed && cur.brk_low > 16'(T_BRK_HOLD_MS))
		begin
			next_cur.brk_send  = 16'(T_BRK_SEND_MS);
			next_cur.brk_armed = 1'b0;
		end
		else if (ms_tick && cur.brk_send != 16'h0000)
			next_cur.brk_send = cur.brk_send - 16'h0001;

		// ****************************************************************
		// call supervision
		// ****************************************************************
		if (cur.pin.ring_n)
		begin
			next_cur.ring_low = 16'h0000;
			next_cur.ring_gap = ms_tick ? sat_inc(cur.ring_gap) : cur.ring_gap;
			if (cur.ring_gap >= 16'(T_RING_GAP_MS))
				next_cur.ring_cnt = 16'h0000;
		end
		else
		begin
			next_cur.ring_gap = 16'h0000;
			next_cur.ring_low = ms_tick ? sat_inc(cur.ring_low) : cur.ring_low;
			if (cur.pin_q.ring_n)
				next_cur.ring_cnt = sat_inc(cur.ring_cnt);
		end
		ring_ok = cur.ctrl_level ? (cur.ring_low >= 16'(T_RING_MS))
			: (cur.ring_cnt >= 16'(RING_CYCLES));

		if (cur.pin.dtr_n)
			next_cur.dtr_hi = ms_tick ? sat_inc(cur.dtr_hi) : cur.dtr_hi;
		else
			next_cur.dtr_hi = 16'h0000;
		dtr_drop  = (cur.dtr_hi >= 16'(T_DTR_MS));
		disc_rise = cur.pin.disc_en && !cur.pin_q.disc_en;

		unique case (cur.call)
			CALL_IDLE:
			begin
				next_cur.hook_ms  = 16'h0000;
				next_cur.disc_ms  = 16'h0000;
				if (!cur.pin.dtr_n && !cur.pin.hook_n)
				begin
					next_cur.call = CALL_WAIT;
					next_cur.orig = 1'b1;
				end
				else if (!cur.pin.dtr_n && ring_ok)
				begin
					next_cur.call     = CALL_WAIT;
					next_cur.orig     = 1'b0;
					next_cur.ring_cnt = 16'h0000;
				end
			end
			CALL_WAIT:
			begin
				// answering counts from entry, originating from hook release
				if ((!cur.orig || cur.pin.hook_n) && ms_tick)
					next_cur.hook_ms = sat_inc(cur.hook_ms);
				if (dtr_drop)
				begin
					next_cur.call       = CALL_DISC;
					next_cur.disc_space = 1'b0;
				end
				else if (cur.hook_ms >= 16'(HOOK_TIMEOUT_MS))
					next_cur.call = CALL_IDLE;
				else if (cur.carrier_ok)
					next_cur.call = CALL_ONLINE;
			end
			CALL_ONLINE:
			begin
				if (dtr_drop)
				begin
					next_cur.call       = CALL_DISC;
					next_cur.disc_space = 1'b0;
				end
				else if (disc_rise)
				begin
					next_cur.call       = CALL_DISC;
					next_cur.disc_space = 1'b1;
				end
				// straps are exclusive, so checking long first decides nothing
				else if (!cur.pin.long_n && cur.rx_sp_ms >= 16'(LONG_SPACE_MS))
					next_cur.call = CALL_IDLE;
				else if (!cur.pin.short_n && cur.rx_sp_ms >= 16'(SHORT_SPACE_MS))
					next_cur.call = CALL_IDLE;
			end
			CALL_DISC:
			begin
				if (ms_tick)
					next_cur.disc_ms = sat_inc(cur.disc_ms);
				if (cur.disc_space && !cur.carrier_ok)
					next_cur.call = CALL_IDLE;
				else if (cur.disc_ms >= 16'(T_DISC_MS))
					next_cur.call = CALL_IDLE;
			end
		endcase

		// ****************************************************************
		// transmit side and handshake outputs
		// ****************************************************************
		next_cur.cts_n  = !(cur.call == CALL_ONLINE && !lost);
		next_cur.rx_brk = next_cur.clamp || next_cur.cts_n;
		if (cur.call == CALL_ONLINE && !lost)
			next_cur.tx_bit = (cur.brk_send != 16'h0000) ? 1'b0 : cur.pin.tx_data;
		else if (cur.call == CALL_DISC && cur.disc_space)
			next_cur.tx_bit = 1'b0;
		else
			next_cur.tx_bit = 1'b1;
		// accumulator keeps running so a tone change has no phase step
		next_cur.inc      = tone_sel(cur.orig, cur.tx_bit);
		next_cur.phase    = cur.phase + cur.inc;
		next_cur.mode_out = mode_calc;
		next_cur.offhook  = (next_cur.call != CALL_IDLE);

		// ****************************************************************
		// ahb-lite slave, zero wait states
		// ****************************************************************
		status_word = '0;
		status_word[STAT_CALL_LSB +: 2] = cur.call;
		status_word[STAT_ORIG]    = cur.orig;
		status_word[STAT_CTS_N]   = cur.cts_n;
		status_word[STAT_RX_BRK]  = cur.rx_brk;
		status_word[STAT_OFFHOOK] = cur.offhook;
		status_word[STAT_CARRIER] = cur.carrier_ok;
		status_word[STAT_LOST]    = lost;
		status_word[STAT_CLAMP]   = cur.clamp;
		status_word[STAT_TX_BIT]  = cur.tx_bit;
		accept = hsel && htrans[1] && hready;
		next_cur.hreadyout = 1'b1;
		next_cur.hresp     = 1'b0;
		next_cur.wr_pend   = accept && hwrite && (hsize == HSIZE_WORD);
		if (accept)
			next_cur.wr_addr = haddr[7:0];
		if (accept && !hwrite)
		begin
			unique case (haddr[7:0])
				ADDR_CTRL:   next_cur.hrdata = {31'h00000000, cur.ctrl_level};
				ADDR_LOSS:   next_cur.hrdata = {16'h0000, cur.loss_limit};
				ADDR_STATUS: next_cur.hrdata = status_word;
				default:     next_cur.hrdata = 32'h00000000;
			endcase
		end
		if (cur.wr_pend && cur.wr_addr == ADDR_CTRL)
			next_cur.ctrl_level = hwdata[CTRL_RING_LVL];
		if (cur.wr_pend && cur.wr_addr == ADDR_LOSS)
			next_cur.loss_limit = hwdata[15:0];
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			cur <= RESET_STATE;
		else
			cur <= next_cur;
	end

	assign hreadyout       = cur.hreadyout;
	assign hresp           = cur.hresp;
	assign hrdata          = cur.hrdata;
	assign rx_serial_out   = cur.rx_out;
	assign rx_break_flag   = cur.rx_brk;
	assign clear_to_send_n = cur.cts_n;
	assign originate_mode  = cur.mode_out;
	assign tone_freq_out   = cur.phase[31];
	assign tx_tone_out     = cur.phase[31];
	assign offhook_drive   = cur.offhook;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_brk_load;
		(cur.brk_send == 16'h0000) ##1 (cur.brk_send != 16'h0000);
	endsequence
	sequence s_disc_loss;
		(cur.call == CALL_DISC) && cur.disc_space && !cur.carrier_ok;
	endsequence

	property p_brk_len;
		s_brk_load |-> (cur.brk_send == 16'(T_BRK_SEND_MS));
	endproperty
	a_brk_len: assert property (p_brk_len) else $error("break space not loaded with 233 ms");

	property p_brk_space;
		(cur.brk_send != 16'h0000 && cur.call == CALL_ONLINE && !lost) |=> !cur.tx_bit;
	endproperty
	a_brk_space: assert property (p_brk_space) else $error("mark sent during break");

	property p_cts_online;
		!clear_to_send_n |-> $past(cur.call) == CALL_ONLINE;
	endproperty
	a_cts_online: assert property (p_cts_online) else $error("clear to send outside online");

	property p_rx_break_flag_cts;
		clear_to_send_n |-> rx_break_flag;
	endproperty
	a_rx_break_flag_cts: assert property (p_rx_break_flag_cts) else $error("receive break not clamped");

	property p_release;
		(cur.clamp && cur.rel_us >= 16'(T_BRK_REL_US) && !clamp_set) |=> !cur.clamp ##1 !rx_break_flag || clear_to_send_n;
	endproperty
	a_release: assert property (p_release) else $error("break clear ignored");

	property p_mode;
		originate_mode == $past(mode_calc);
	endproperty
	a_mode: assert property (p_mode) else $error("mode output wrong");

	property p_offhook;
		(cur.call == CALL_IDLE && !cur.pin.dtr_n && (!cur.pin.hook_n || ring_ok)) |=> offhook_drive;
	endproperty
	a_offhook: assert property (p_offhook) else $error("off-hook drive out of step");

	property p_tone;
		$changed(cur.tx_bit) |-> ##[1:2] (cur.inc == tone_sel(cur.orig, cur.tx_bit));
	endproperty
	a_tone: assert property (p_tone) else $error("tone not switched in time");

	property p_space;
		(cur.rx_half >= rx_thresh && cur.carrier_ok) |=> (!rx_serial_out || !cur.carrier_ok);
	endproperty
	a_space: assert property (p_space) else $error("long half-cycle not space");

	property p_disc_loss;
		s_disc_loss |=> (cur.call == CALL_IDLE);
	endproperty
	a_disc_loss: assert property (p_disc_loss) else $error("space disconnect ignored loss");

	property p_lost;
		lost |=> clear_to_send_n;
	endproperty
	a_lost: assert property (p_lost) else $error("clear to send kept on loss");

	property p_hook;
		(cur.call == CALL_WAIT && !dtr_drop && cur.hook_ms >= 16'(HOOK_TIMEOUT_MS)) |=> !offhook_drive;
	endproperty
	a_hook: assert property (p_hook) else $error("no hang-up after hook timeout");

endmodule

// [bench/terminal_model.sv]
// terminal side model: terminal ready, transmit data, break request and break release lines
`timescale 1ns/1ps
module terminal_model
(
	input  wire logic sys_clk,
	input  wire logic ready,
	input  wire logic brk,
	input  wire logic clr,
	input  wire logic cts_n,
	output logic      term_ready_n,
	output logic      tx_serial_in,
	output logic      tx_break_req_n,
	output logic      break_clear_n
);
	// break request falls only while clear to send is low, after standing high since reset
	initial
	begin
		term_ready_n   = 1'b1;
		tx_serial_in   = 1'b1;
		tx_break_req_n = 1'b1;
		break_clear_n  = 1'b1;
	end
	always @(posedge sys_clk)
	begin
		term_ready_n   <= ~ready;
		tx_break_req_n <= ~(brk && !cts_n);
		break_clear_n  <= ~clr;
	end
endmodule

// [bench/fsk_modem_supervisory_control_tb.sv]
// self-checking bench of the fsk modem supervisory block over its register bus and pins
`timescale 1ns/1ps
module fsk_modem_supervisory_control_tb;
	import modem_pkg::*;
	logic        sys_clk, sys_rst, hsel, hwrite, ready, hook_n, lvl_n, loop_n;
	logic [31:0] haddr, hwdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        fast, disc_en, long_n, short_n, ring_n, rx_tone, brk, clr;
	wire         hreadyout, hresp, rx_out, rx_brk, cts_n, orig, tone_f, tone_tx, offhook;
	wire         trn, txd, brkn, clrn;
	wire  [31:0] hrdata;
	int          fails, compares;
	// ****************************************************************
	// clock, stimulus defaults and reset
	// ****************************************************************
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		{hsel, hwrite, ready, fast, disc_en, rx_tone, brk, clr} = 8'h00;
		{hook_n, lvl_n, loop_n, long_n, short_n, ring_n} = 6'h3F;
		{haddr, hwdata, htrans, hsize, fails, compares} = '0;
		sys_rst = 1'b1;
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
	end
	terminal_model i_terminal_model (.sys_clk(sys_clk), .ready(ready), .brk(brk), .clr(clr), .cts_n(cts_n),
		.term_ready_n(trn),
		.tx_serial_in(txd), .tx_break_req_n(brkn), .break_clear_n(clrn));
	// short timer figures: one ms is 8 cycles here
	fsk_modem_supervisory_control #(.CYC_PER_US(2), .US_PER_MS(4), .HOOK_TIMEOUT_MS(20))
	i_fsk_modem_supervisory_control (.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.tx_serial_in(txd), .tx_break_req_n(brkn), .break_clear_n(clrn),
		.loopback_test_n(loop_n), .fast_test_en(fast), .space_disc_en(disc_en),
		.long_space_hangup_n(long_n), .short_space_hangup_n(short_n), .hook_switch_n(hook_n),
		.ring_ind_n(ring_n), .term_ready_n(trn), .carrier_level_ok_n(lvl_n),
		.rx_tone_in(rx_tone), .rx_serial_out(rx_out), .rx_break_flag(rx_brk),
		.clear_to_send_n(cts_n), .originate_mode(orig), .tone_freq_out(tone_f),
		.tx_tone_out(tone_tx), .offhook_drive(offhook));
	// ****************************************************************
	// bus and compare tasks
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h000000, a};
		hwrite <= w;
		hsize  <= HSIZE_WORD;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		q = hrdata;
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ****************************************************************
	// tests
	// ****************************************************************
	initial
	begin
		#600000;
		fails++;
		summarize();
	end
	initial
	begin
		@(negedge sys_rst);
		chk("idle", {rx_out, rx_brk, cts_n, orig, offhook}, 32'h1C);
		bus(ADDR_LOSS, 1'b0, 32'h0);
		chk("loss", q, 32'h000001F4);
		bus(8'h0C, 1'b0, 32'h0);
		chk("unmapped", q, 32'h0);
		bus(ADDR_CTRL, 1'b1, 32'h1);
		bus(ADDR_STATUS, 1'b1, 32'hFFFFFFFF);
		bus(ADDR_CTRL, 1'b0, 32'h0);
		chk("ctrl", q, 32'h1);
		bus(ADDR_LOSS, 1'b1, 32'h8);
		bus(ADDR_LOSS, 1'b0, 32'h0);
		chk("loss_wr", q, 32'h8);
		// originate: hook switch with terminal ready, level held present
		ready  <= 1'b1;
		hook_n <= 1'b0;
		lvl_n  <= 1'b0;
		repeat (400) if (cts_n !== 1'b0) @(posedge sys_clk);
		chk("cts_n", cts_n, 32'h0);
		chk("offhook", offhook, 32'h1);
		chk("orig", orig, 32'h1);
		chk("rx_brk_on", rx_brk, 32'h0);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("status", q & 32'h6F, 32'h67);
		chk("tone", tone_f, tone_tx);
		loop_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		chk("loop_mode", orig, 32'h0);
		chk("loop_cts", cts_n, 32'h0);
		loop_n <= 1'b1;
		repeat (20) @(posedge sys_clk);
		chk("mode_back", orig, 32'h1);
		// steady space tone clamps receive break; break clear releases it after 20 us
		repeat (3000) if (rx_brk !== 1'b1) @(posedge sys_clk);
		chk("rx_clamp", rx_brk, 32'h1);
		clr <= 1'b1;
		repeat (30) @(posedge sys_clk);
		chk("rel_early", rx_brk, 32'h1);
		repeat (30) @(posedge sys_clk);
		chk("released", rx_brk, 32'h0);
		clr <= 1'b0;
		// transmit break: space after 34 ms low, held for 233 ms
		brk <= 1'b1;
		repeat (250) @(posedge sys_clk);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("brk_early", q[STAT_TX_BIT], 32'h1);
		repeat (60) @(posedge sys_clk);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("brk_space", q[STAT_TX_BIT], 32'h0);
		brk <= 1'b0;
		repeat (2000) @(posedge sys_clk);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("brk_end", q[STAT_TX_BIT], 32'h1);
		// level pulses stop: channel kept over the 32 ms gap, then loss drops clear to send
		lvl_n <= 1'b1;
		repeat (200) @(posedge sys_clk);
		chk("gap_kept", cts_n, 32'h0);
		repeat (400) if (cts_n !== 1'b1) @(posedge sys_clk);
		chk("loss_cts", cts_n, 32'h1);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("loss_stat", q & 32'h2C3, 32'h283);
		lvl_n <= 1'b0;
		repeat (100) @(posedge sys_clk);
		chk("loss_back", cts_n, 32'h0);
		// terminal ready withdrawn: disconnect after 34 ms plus 3 s
		ready  <= 1'b0;
		hook_n <= 1'b1;
		repeat (200) @(posedge sys_clk);
		chk("disc_wait", offhook, 32'h1);
		repeat (30000) if (offhook !== 1'b0) @(posedge sys_clk);
		chk("disc_done", offhook, 32'h0);
		// answer on a level ring held 51 ms, then space disconnect cut short by level loss
		ring_n <= 1'b0;
		ready  <= 1'b1;
		repeat (300) @(posedge sys_clk);
		chk("ring_early", offhook, 32'h0);
		repeat (300) if (offhook !== 1'b1) @(posedge sys_clk);
		chk("ans_hook", offhook, 32'h1);
		repeat (20) @(posedge sys_clk);
		chk("ans_mode", orig, 32'h0);
		ring_n  <= 1'b1;
		disc_en <= 1'b1;
		repeat (4) @(posedge sys_clk);
		disc_en <= 1'b0;
		repeat (10) @(posedge sys_clk);
		bus(ADDR_STATUS, 1'b0, 32'h0);
		chk("sp_disc", q & 32'h203, 32'h2);
		lvl_n <= 1'b1;
		repeat (400) if (offhook !== 1'b0) @(posedge sys_clk);
		chk("sp_loss", offhook, 32'h0);
		// origination that never completes hangs up after the hook timeout
		hook_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		hook_n <= 1'b1;
		repeat (100) @(posedge sys_clk);
		chk("hook_wait", offhook, 32'h1);
		repeat (200) if (offhook !== 1'b0) @(posedge sys_clk);
		chk("hook_drop", offhook, 32'h0);
		summarize();
	end
endmodule
